/* File: rtl/mcuix_exec.sv */
// Purpose: Executes OR-with-file, I/O-page write/read, long jump, long call, move to file.
// Assumes: File and I/O-page reads are combinational from the addresses presented.
// Notes: Stack overflow wraps; the rest of the core owns pops and other opcodes.
`timescale 1ns/1ns
// Contract
// RL1: OR work register with file register 0..127, result to work if dest 0 else file, Z set, 1 cycle.
// RL2: When OR result goes to the file register the work register stays, and Z clears if nonzero.
// RL3: I/O-page write copies work register to I/O-page register 5..15, no flags, 1 cycle.
// RL4: I/O-page read copies I/O-page register 5..15 to work register, no flags, 1 cycle.
// RL5: Long jump loads 11-bit address 0..2047 into the program counter, no flags, 2 cycles.
// RL6: Long call pushes next address, loads 11-bit target, no flags, 2 cycles.
// RL7: Long call stores return address at current stack level then increments the stack pointer.
// RL8: Move work to file writes work register to file register 0..127, no flags, 1 cycle.
// RL9: Jump and call discard the prefetched instruction and fetch from the new counter.
module mcuix_exec
    import mcuix_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input wire logic I_CLK,
    input wire logic I_SYS_RST,
    input wire mcuix_instr_t I_INSTR,
    input wire logic [DATA_W-1:0] I_FILE_RDATA,
    input wire logic [DATA_W-1:0] I_IO_RDATA,
    output logic [FADDR_W-1:0] O_FILE_RADDR,
    output logic [IOADDR_W-1:0] O_IO_RADDR,
    output mcuix_fwr_t O_FILE_WR,
    output mcuix_iowr_t O_IO_WR,
    output logic [DATA_W-1:0] O_WORK,
    output logic O_ZERO,
    output logic [PC_W-1:0] O_PC,
    output logic [SP_W-1:0] O_SP,
    output logic O_FLUSH,
    output logic O_BUSY
);
    logic [DATA_W-1:0] work_q, work_d;
    logic zero_q, zero_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [SP_W-1:0] sp_q, sp_d;
    logic [PC_W-1:0] stack_q [DEPTH];
    mcuix_fwr_t fwr_q, fwr_d;
    mcuix_iowr_t iowr_q, iowr_d;
    logic flush_q;
    logic busy_q;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_REFILL = 2'b10
    } mcuix_state_t;
    mcuix_state_t state_q, state_d;

    function automatic logic io_ok(input logic [IOADDR_W-1:0] a);
        return (a >= IO_FIRST) && (a <= IO_LAST);
    endfunction

    // The slot after a jump or call holds a stale prefetch and is dropped.
    wire logic run = I_INSTR.valid && (state_q == ST_RUN); // RL9
    wire logic is_or = run && (I_INSTR.op == OP_OR_WORK_WITH_FILE_REG);
    wire logic is_iow = run && (I_INSTR.op == OP_WRITE_IO_PAGE_REG);
    wire logic is_ior = run && (I_INSTR.op == OP_READ_IO_PAGE_REG);
    wire logic is_jmp = run && (I_INSTR.op == OP_LONG_JUMP);
    wire logic is_call = run && (I_INSTR.op == OP_LONG_SUBROUTINE_CALL);
    wire logic is_mov = run && (I_INSTR.op == OP_MOVE_WORK_TO_FILE_REG);
    wire logic [IOADDR_W-1:0] io_sel = I_INSTR.faddr[IOADDR_W-1:0];
    wire logic [DATA_W-1:0] or_res = work_q | I_FILE_RDATA; // RL1
    wire logic [PC_W-1:0] pc_next = pc_q + 11'h001;

    always_comb begin
        work_d = work_q;
        zero_d = zero_q;
        pc_d = run ? pc_next : pc_q;
        sp_d = sp_q;
        fwr_d = '0;
        iowr_d = '0;
        if (is_or) begin
            zero_d = (or_res == 8'h00); // RL1 RL2
            if (I_INSTR.dest) begin
                fwr_d = '{wr: 1'b1, addr: I_INSTR.faddr, data: or_res}; // RL2
            end else begin
                work_d = or_res; // RL1
            end
        end
        if (is_iow && io_ok(io_sel)) begin
            iowr_d = '{wr: 1'b1, addr: io_sel, data: work_q}; // RL3
        end
        if (is_ior && io_ok(io_sel)) begin
            work_d = I_IO_RDATA; // RL4
        end
        if (is_mov) begin
            fwr_d = '{wr: 1'b1, addr: I_INSTR.faddr, data: work_q}; // RL8
        end
        if (is_jmp || is_call) begin
            pc_d = I_INSTR.target; // RL5 RL6
        end
        if (is_call) begin
            sp_d = sp_q + 3'h1; // RL7
        end
    end

    // Only a taken jump or call opens the refill slot, and that slot always hands back to run.
    // The two unused codes fall back to run so a corrupted state cannot freeze the core.
    always_comb begin
        unique case (state_q)
            ST_RUN: begin
                state_d = (is_jmp || is_call) ? ST_REFILL : ST_RUN; // RL9
            end
            ST_REFILL: begin
                state_d = ST_RUN;
            end
            default: begin
                state_d = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_SYS_RST) begin
            work_q <= WORK_RST;
            zero_q <= 1'b0;
            pc_q <= PC_RST;
            sp_q <= SP_RST;
            state_q <= ST_RUN;
            fwr_q <= '0;
            iowr_q <= '0;
            flush_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            work_q <= work_d;
            zero_q <= zero_d;
            pc_q <= pc_d;
            sp_q <= sp_d;
            state_q <= state_d;
            fwr_q <= fwr_d;
            iowr_q <= iowr_d;
            flush_q <= is_jmp || is_call; // RL9
            busy_q <= (state_d == ST_REFILL); // RL9
        end
    end

    // The return slot is plain storage; no reset is needed since the pointer guards it.
    // Overflow wraps, so a call nested one level too deep overwrites the oldest return address.
    always_ff @(posedge I_CLK) begin
        if (is_call && !I_SYS_RST) begin
            stack_q[sp_q] <= pc_next; // RL6 RL7
        end
    end

    // Read addresses pass straight from the fetch stage because both pages answer in
    // the same cycle; a flop here would cost every read instruction an extra cycle.
    assign O_FILE_RADDR = I_INSTR.faddr;
    assign O_IO_RADDR = io_sel;
    assign O_FILE_WR = fwr_q;
    assign O_IO_WR = iowr_q;
    assign O_WORK = work_q;
    assign O_ZERO = zero_q;
    assign O_PC = pc_q;
    assign O_SP = sp_q;
    assign O_FLUSH = flush_q;
    assign O_BUSY = busy_q;

    chk_or_to_work: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL1
        is_or && !I_INSTR.dest |=> work_q == $past(or_res) && zero_q == ($past(or_res) == 8'h00))
        else $error("OR to work wrong");
    chk_or_to_file: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL2
        is_or && I_INSTR.dest |=> $stable(work_q) && fwr_q.wr && fwr_q.data == $past(or_res)
        && (zero_q == ($past(or_res) == 8'h00)))
        else $error("OR to file wrong");
    chk_io_write: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL3
        is_iow && io_ok(io_sel) |=> iowr_q.wr && iowr_q.data == $past(work_q) && $stable(zero_q))
        else $error("I/O write wrong");
    chk_io_read: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL4
        is_ior && io_ok(io_sel) |=> work_q == $past(I_IO_RDATA) && !iowr_q.wr && $stable(zero_q))
        else $error("I/O read wrong");
    chk_jump_pc: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL5
        is_jmp |=> pc_q == $past(I_INSTR.target) && O_BUSY && $stable(zero_q) ##1 !O_BUSY)
        else $error("Jump wrong");
    chk_call_push: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL7
        is_call |=> sp_q == $past(sp_q) + 3'h1 && stack_q[$past(sp_q)] == $past(pc_next))
        else $error("Call push wrong");
    chk_call_pc: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL6
        is_call |=> pc_q == $past(I_INSTR.target) && $stable(work_q) && O_FLUSH)
        else $error("Call target wrong");
    chk_move_file: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL8
        is_mov |=> fwr_q.wr && fwr_q.data == $past(work_q) && $stable(work_q) && $stable(zero_q))
        else $error("Move wrong");
    chk_refill_drop: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL9
        O_BUSY |=> !fwr_q.wr && !iowr_q.wr && $stable(work_q))
        else $error("Prefetch not dropped");

    // Refused operands, untouched flags and the refill slot.
    // Each of these would still pass if only the positive cases above were checked.
    chk_io_write_skip: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL3
        is_iow && !io_ok(io_sel) |=> !iowr_q.wr && !fwr_q.wr && $stable(work_q))
        else $error("Out-of-page I/O write not dropped");
    chk_io_read_skip: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL4
        is_ior && !io_ok(io_sel) |=> $stable(work_q) && $stable(zero_q))
        else $error("Out-of-page I/O read changed work register");
    chk_flags_kept: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL3 RL4 RL8
        run && !is_or |=> $stable(zero_q))
        else $error("Zero flag changed by non-OR instruction");
    chk_pc_advance: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL1 RL8
        run && !is_jmp && !is_call |=> pc_q == $past(pc_next) && !O_BUSY)
        else $error("One-cycle instruction did not advance counter");
    chk_call_two: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL6
        is_call |=> O_BUSY && O_FLUSH ##1 !O_BUSY && !O_FLUSH)
        else $error("Call did not take two cycles");
    chk_jump_stack: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL5
        is_jmp |=> $stable(sp_q) && $stable(work_q) && !fwr_q.wr)
        else $error("Jump touched stack or work register");
    chk_refill_hold: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL9
        O_BUSY |=> $stable(pc_q) && $stable(sp_q))
        else $error("Counter moved in refill slot");
    chk_write_addr: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL8
        is_mov |=> fwr_q.addr == $past(I_INSTR.faddr))
        else $error("Move wrote wrong file address");
    chk_or_addr: assert property (@(posedge I_CLK) disable iff (I_SYS_RST) // RL2
        is_or && I_INSTR.dest |=> fwr_q.addr == $past(I_INSTR.faddr))
        else $error("OR wrote wrong file address");

    cov_or_file: cover property (@(posedge I_CLK) is_or && I_INSTR.dest);
    cov_call: cover property (@(posedge I_CLK) is_call);
    cov_jump: cover property (@(posedge I_CLK) is_jmp);
    cov_io_rw: cover property (@(posedge I_CLK) is_iow ##1 is_ior);
    cov_refill_drop: cover property (@(posedge I_CLK) O_BUSY && I_INSTR.valid);
endmodule // mcuix_exec

/* File: rtl/mcuix_pkg.sv */
// Purpose: Shared constants and types for the instruction subset executor.
// Assumes: 8-bit data, 11-bit program counter, 7-bit file register address.
// Notes: Opcode values are an internal encoding of this block.
package mcuix_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 11;
    localparam int FADDR_W = 7;
    localparam int IOADDR_W = 4;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam logic [3:0] IO_FIRST = 4'h5;
    localparam logic [3:0] IO_LAST = 4'hF;
    localparam logic [PC_W-1:0] PC_RST = 11'h000;
    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
    localparam logic [SP_W-1:0] SP_RST = 3'h0;
    localparam int ONE_CYCLE = 1;
    localparam int TWO_CYCLE = 2;

    typedef enum logic [2:0] {
        OP_NOP = 3'h0,
        OP_OR_WORK_WITH_FILE_REG = 3'h1,
        OP_WRITE_IO_PAGE_REG = 3'h2,
        OP_READ_IO_PAGE_REG = 3'h3,
        OP_LONG_JUMP = 3'h4,
        OP_LONG_SUBROUTINE_CALL = 3'h5,
        OP_MOVE_WORK_TO_FILE_REG = 3'h6
    } mcuix_op_t;

    // Decoded instruction word as handed in by the fetch stage.
    typedef struct packed {
        logic valid;
        mcuix_op_t op;
        logic dest;
        logic [FADDR_W-1:0] faddr;
        logic [PC_W-1:0] target;
    } mcuix_instr_t;

    typedef struct packed {
        logic wr;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mcuix_fwr_t;

    typedef struct packed {
        logic wr;
        logic [IOADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mcuix_iowr_t;
endpackage

/* File: verification/mcuix_tb.sv */
// Purpose: Self-checking bench for the instruction subset executor.
// Assumes: Effects appear just after the edge that takes an instruction, one cycle after it is presented.
// Notes: File and I/O read data share one driven value to keep the bench small.
`timescale 1ns/1ns
module testbench;
import mcuix_pkg::*;
logic I_CLK = 1'b0;
logic I_SYS_RST = 1'b1;
mcuix_instr_t I_INSTR = '0;
logic [7:0] I_FILE_RDATA = 8'h00;
logic [7:0] I_IO_RDATA = 8'h00;
logic [6:0] O_FILE_RADDR;
logic [3:0] O_IO_RADDR;
mcuix_fwr_t O_FILE_WR;
mcuix_iowr_t O_IO_WR;
logic [7:0] O_WORK;
logic O_ZERO;
logic [10:0] O_PC;
logic [2:0] O_SP;
logic O_FLUSH;
logic O_BUSY;
int err_total = 0;
int tests_run = 0;
logic [10:0] exp_pc = 11'h000;
always #5 I_CLK = ~I_CLK;
mcuix_exec DUT (.I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_INSTR(I_INSTR),
    .I_FILE_RDATA(I_FILE_RDATA), .I_IO_RDATA(I_IO_RDATA), .O_FILE_RADDR(O_FILE_RADDR),
    .O_IO_RADDR(O_IO_RADDR), .O_FILE_WR(O_FILE_WR), .O_IO_WR(O_IO_WR), .O_WORK(O_WORK),
    .O_ZERO(O_ZERO), .O_PC(O_PC), .O_SP(O_SP), .O_FLUSH(O_FLUSH), .O_BUSY(O_BUSY));
task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp) begin
        err_total++;
        $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
endtask
task automatic issue(input mcuix_op_t op, input logic d, input logic [6:0] fa,
    input logic [10:0] tg, input logic [7:0] rd);
    @(posedge I_CLK);
    I_INSTR <= '{1'b1, op, d, fa, tg};
    I_FILE_RDATA <= rd;
    I_IO_RDATA <= rd;
    @(posedge I_CLK);
    I_INSTR.valid <= 1'b0;
    #1;
    exp_pc = exp_pc + 11'h001;
    chk(O_PC, exp_pc);
endtask
task automatic t_or_read;
    issue(OP_OR_WORK_WITH_FILE_REG, 1'b0, 7'h00, 11'h000, 8'h00);
    chk({O_WORK, O_ZERO, O_FILE_WR.wr}, {8'h00, 2'b10});
    issue(OP_READ_IO_PAGE_REG, 1'b0, 7'h05, 11'h000, 8'hAA);
    chk({O_WORK, O_ZERO, O_IO_RADDR, O_IO_WR.wr}, {8'hAA, 1'b1, 4'h5, 1'b0});
    issue(OP_OR_WORK_WITH_FILE_REG, 1'b1, 7'h7F, 11'h000, 8'h50);
    chk(O_FILE_WR, {1'b1, 7'h7F, 8'hFA});
    chk({O_WORK, O_ZERO, O_FILE_RADDR}, {8'hAA, 1'b0, 7'h7F});
endtask
task automatic t_io_write;
    logic [3:0] ops [3];
    ops = '{4'h4, 4'h5, 4'hF};
    foreach (ops[k]) begin
        issue(OP_WRITE_IO_PAGE_REG, 1'b0, {3'h0, ops[k]}, 11'h000, 8'h00);
        chk(O_IO_WR, (k == 0) ? 13'h0000 : {1'b1, ops[k], 8'hAA});
        chk({O_WORK, O_ZERO}, {8'hAA, 1'b0});
    end
    issue(OP_READ_IO_PAGE_REG, 1'b0, 7'h04, 11'h000, 8'h33);
    chk({O_WORK, O_ZERO, O_IO_RADDR}, {8'hAA, 1'b0, 4'h4});
endtask
task automatic t_move;
    issue(OP_MOVE_WORK_TO_FILE_REG, 1'b0, 7'h7F, 11'h000, 8'h00);
    chk(O_FILE_WR, {1'b1, 7'h7F, 8'hAA});
    chk({O_WORK, O_ZERO}, {8'hAA, 1'b0});
endtask
task automatic t_jump;
    @(posedge I_CLK);
    I_INSTR <= '{1'b1, OP_LONG_JUMP, 1'b0, 7'h00, 11'h7FF};
    @(posedge I_CLK);
    // Stale prefetch is presented while the refill cycle runs.
    I_INSTR <= '{1'b1, OP_MOVE_WORK_TO_FILE_REG, 1'b0, 7'h01, 11'h000};
    #1;
    chk({O_PC, O_FLUSH, O_BUSY, O_ZERO}, {11'h7FF, 3'b110});
    @(posedge I_CLK);
    I_INSTR.valid <= 1'b0;
    #1;
    chk({O_FILE_WR.wr, O_BUSY, O_FLUSH, O_PC}, {3'b000, 11'h7FF});
    exp_pc = 11'h7FF;
endtask
task automatic t_call;
    exp_pc = 11'h122;
    issue(OP_LONG_SUBROUTINE_CALL, 1'b0, 7'h00, 11'h123, 8'h00);
    chk({O_SP, O_FLUSH, O_BUSY, O_ZERO}, {3'h1, 3'b110});
    exp_pc = 11'h044;
    issue(OP_LONG_SUBROUTINE_CALL, 1'b0, 7'h00, 11'h045, 8'h00);
    chk({O_SP, O_WORK}, {3'h2, 8'hAA});
endtask
// Mid-run reset, with an instruction waiting on the first edge after release.
task automatic t_reset;
    @(posedge I_CLK);
    I_SYS_RST <= 1'b1;
    @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    I_INSTR <= '{1'b1, OP_OR_WORK_WITH_FILE_REG, 1'b0, 7'h00, 11'h000};
    I_FILE_RDATA <= 8'h00;
    #1;
    chk({O_WORK, O_ZERO, O_PC}, 20'h00000);
    chk({O_SP, O_FLUSH, O_BUSY, O_FILE_WR.wr, O_IO_WR.wr}, 7'h00);
    @(posedge I_CLK);
    I_INSTR.valid <= 1'b0;
    #1;
    chk({O_WORK, O_ZERO, O_PC}, {8'h00, 1'b1, 11'h001});
    exp_pc = 11'h001;
endtask
task automatic print_verdict;
    if (err_total == 0 && tests_run > 0) begin
        $display("All checks passed");
    end else begin
        $display("Checks failed");
    end
    $finish;
endtask
initial begin
    repeat (12) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    t_or_read();
    t_io_write();
    t_move();
    t_jump();
    t_call();
    t_reset();
    t_or_read();
    print_verdict();
end
initial begin
    #20000;
    err_total++;
    print_verdict();
end
endmodule // testbench
